/* File: core/dar_core.sv */
// Serial readout and conversion sequencing of a 12-bit differential converter.
// What this block does
// - Select rise abandons the running conversion.
// - Each bit leaves as its step resolves.
// - Only a fresh select fall starts conversion.
// - Analog side sleeps once conversion completes.
// - After last bit, shifter sleeps, output floats.
// - Select low at fall fifteen extends output.
// - Select fall during clock high: one early.
// - Sampling lasts until second clock fall.
// - Null bit, then twelve bits MSB first.
// - Early rise floats after LSB; else repeat.
// - Result is twelve-bit two's complement.
// - Power down on select rise or fall fourteen.
`default_nettype none
module dar_core (
    // Clocking.
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Serial link pins.
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    output logic dout,
    output logic dout_oe,
    // Analog front end samples, two's complement.
    input wire logic [dar_pkg::WORD_W-1:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    // Power and status.
    output logic sampling,
    output logic analog_on,
    output logic shift_on,
    output logic sample_missing,
    output logic [dar_pkg::WORD_W-1:0] result,
    output logic result_valid
);
    import dar_pkg::*;

    // ****************************************
    // Pin synchronisation and edge detection.
    // ****************************************
    logic [1:0] pins_q;
    logic cs_prev_q;
    logic sclk_prev_q;
    dar_state_e state_q;
    dar_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [WORD_W-1:0] word_q;
    logic dout_q;
    logic dout_oe_q;
    logic sampling_q;
    logic analog_on_q;
    logic shift_on_q;
    logic missing_q;
    logic [WORD_W-1:0] result_q;
    logic result_valid_q;
    logic [WORD_W-1:0] fifo_data;
    logic fifo_valid;

    dar_sync #(
        .W(2),
        .RST_VAL({CS_N_RST, SCLK_RST})
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .clk_en(clk_en),
        .pin_in({cs_n_pin, sclk_pin}),
        .level_q(pins_q)
    );

    wire cs_n_lvl = pins_q[1];
    wire sclk_lvl = pins_q[0];
    wire cs_fall = cs_prev_q && !cs_n_lvl;
    wire cs_rise = !cs_prev_q && cs_n_lvl;
    wire sclk_fall = sclk_prev_q && !sclk_lvl;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cs_prev_q <= CS_N_RST;
            sclk_prev_q <= SCLK_RST;
        end else if (clk_en) begin
            cs_prev_q <= cs_n_lvl;
            sclk_prev_q <= sclk_lvl;
        end
    end

    // ****************************************
    // Frame decode.
    // ****************************************
    // clock in frame only
    wire in_frame = (state_q != DAR_IDLE) && (state_q != DAR_DONE);
    wire step = sclk_fall && in_frame && !cs_rise && !cs_fall;
    wire [CNT_W-1:0] next_cnt = cnt_q + 5'h01;
    wire at_null = step && (next_cnt == FALL_NULL);
    wire at_shift = step && (next_cnt >= FALL_MSB) && (next_cnt <= FALL_LSB);
    wire at_repeat = step && (next_cnt >= FALL_REPEAT) && (next_cnt <= FALL_LAST);
    wire at_off = step && (next_cnt == FALL_OFF);
    wire at_lsb = step && (next_cnt == FALL_LSB);
    wire [3:0] msb_idx = 4'(FALL_LSB - next_cnt);
    wire [3:0] rep_idx = 4'(next_cnt - FALL_LSB);
    wire [3:0] bit_idx = at_repeat ? rep_idx : msb_idx;
    wire early = cs_fall && sclk_prev_q;

    // ****************************************
    // Frame state machine.
    // ****************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (cs_rise) begin
            state_d = DAR_IDLE;
            cnt_d = '0;
        end else if (cs_fall) begin
            state_d = DAR_SAMPLE;
            cnt_d = early ? 5'h01 : 5'h00;
        end else if (step) begin
            cnt_d = next_cnt;
            // The count ranges nest, so they are tested in priority order.
            if (next_cnt < FALL_NULL) begin
                state_d = DAR_SAMPLE;
            end else if (next_cnt <= FALL_LSB) begin
                state_d = DAR_SHIFT;
            end else if (next_cnt <= FALL_LAST) begin
                // select still low at fall fifteen
                state_d = DAR_REPEAT;
            end else begin
                state_d = DAR_DONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= DAR_IDLE;
            cnt_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ****************************************
    // Sample capture from the FIFO.
    // ****************************************
    // sample closes at second fall
    wire take = clk_en && at_null;

    dar_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .clk_en(clk_en),
        .in_data(sample_data),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(at_null)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            word_q <= WORD_RST;
            missing_q <= 1'b0;
        end else if (take) begin
            word_q <= fifo_valid ? fifo_data : WORD_RST;
            missing_q <= !fifo_valid;
        end
    end

    // ****************************************
    // Serial output.
    // ****************************************
    // bit driven on its own step
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dout_q <= 1'b0;
        end else if (clk_en && (at_shift || at_repeat)) begin
            dout_q <= word_q[bit_idx];
        end else if (clk_en && at_null) begin
            dout_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dout_oe_q <= 1'b0;
        end else if (clk_en && (cs_rise || cs_fall || at_off)) begin
            dout_oe_q <= 1'b0;
        end else if (clk_en && at_null) begin
            dout_oe_q <= 1'b1;
        end
    end

    // ****************************************
    // Power sequencing and result.
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sampling_q <= 1'b0;
            analog_on_q <= 1'b0;
            shift_on_q <= 1'b0;
        end else if (clk_en) begin
            sampling_q <= cs_fall || (sampling_q && !at_null && !cs_rise);
            // power down at select rise or fall fourteen
            analog_on_q <= cs_fall || (analog_on_q && !at_lsb && !cs_rise);
            shift_on_q <= cs_fall || (shift_on_q && !at_off && !cs_rise);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            result_q <= WORD_RST;
            result_valid_q <= 1'b0;
        end else if (clk_en) begin
            result_valid_q <= at_lsb;
            if (at_lsb) begin
                result_q <= word_q;
            end
        end
    end

    assign dout = dout_q;
    assign dout_oe = dout_oe_q;
    assign sampling = sampling_q;
    assign analog_on = analog_on_q;
    assign shift_on = shift_on_q;
    assign sample_missing = missing_q;
    assign result = result_q;
    assign result_valid = result_valid_q;

    // ****************************************
    // Assertions.
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_msb_step;
        clk_en && at_shift && next_cnt == FALL_MSB;
    endsequence

    sequence s_frame_start;
        clk_en && cs_fall;
    endsequence

    sequence s_frame_opened;
        sampling_q && analog_on_q && shift_on_q && !dout_oe_q && state_q == DAR_SAMPLE;
    endsequence

    a_abandon_on_rise: assert property (clk_en && cs_rise |=> !dout_oe_q
        && !analog_on_q && !shift_on_q && state_q == DAR_IDLE)
        else $error("Select rise did not abandon the frame.");
    a_frame_opens: assert property (s_frame_start |=> s_frame_opened)
        else $error("Select fall did not open a sampling frame.");
    a_repeat_lsb_first: assert property (clk_en && at_repeat
        |=> dout_q == word_q[$past(rep_idx)])
        else $error("Repeated bit out of order.");
    a_missing_zero: assert property (take && !fifo_valid
        |=> missing_q && word_q == WORD_RST)
        else $error("Empty FIFO not sent as zero.");
    a_result_steady: assert property (!(clk_en && at_lsb) |=> $stable(result_q))
        else $error("Result changed outside conversion end.");
    a_idle_needs_fall: assert property (clk_en && state_q == DAR_IDLE && !cs_fall
        |=> state_q == DAR_IDLE)
        else $error("Frame started without a select fall.");
    a_msb_third_fall: assert property (s_msb_step |=> dout_oe_q && dout_q == word_q[11])
        else $error("MSB not driven on the third fall.");
    a_bit_per_step: assert property (clk_en && at_shift |=> dout_q == word_q[$past(msb_idx)])
        else $error("Output bit does not follow its step.");
    a_null_bit: assert property (clk_en && at_null |=> dout_oe_q && !dout_q && !sampling_q)
        else $error("Null bit or sample close wrong at second fall.");
    a_fresh_fall_only: assert property (clk_en && state_q == DAR_DONE && !cs_rise
        |=> state_q == DAR_DONE && !dout_oe_q)
        else $error("Extra clocks restarted a conversion.");
    a_analog_sleep: assert property (clk_en && at_lsb |=> !analog_on_q
        && result_valid_q && result_q == $past(word_q))
        else $error("Analog side awake after conversion.");
    a_float_after_last: assert property (clk_en && at_off |=> !dout_oe_q && !shift_on_q)
        else $error("Output not floated after last bit.");
    a_repeat_extend: assert property (clk_en && step && next_cnt == FALL_REPEAT
        |=> shift_on_q && dout_oe_q && dout_q == word_q[1])
        else $error("Repeat sequence not entered at fall fifteen.");
    a_early_start: assert property (clk_en && early && !cs_rise |=> cnt_q == 5'h01)
        else $error("Early select fall not offset by one.");
    a_low_power_cs: assert property (clk_en && cs_n_lvl && cs_prev_q
        |=> !analog_on_q && !shift_on_q && !sampling_q)
        else $error("Powered while select high.");
endmodule : dar_core
`default_nettype wire

/* File: core/dar_fifo.sv */
// Sample FIFO with valid and ready on both sides.
`default_nettype none
module dar_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clocking.
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Fill side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = clk_en && in_valid && in_ready;
    wire pop = clk_en && out_valid && out_ready;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_fifo_full_hold: assert property (!in_ready && clk_en && !out_ready |=> !in_ready)
        else $error("FIFO lost its full state without a pop.");
endmodule : dar_fifo
`default_nettype wire

/* File: core/dar_sync.sv */
// Three-stage pin synchroniser with agreement filter, one per bit.
`default_nettype none
module dar_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clocking.
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Pins and filtered levels.
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_q
);
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    s1_q <= RST_VAL[gi];
                    s2_q <= RST_VAL[gi];
                    s3_q <= RST_VAL[gi];
                end else if (clk_en) begin
                    s1_q <= pin_in[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // A change counts only once the last two stages agree.
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    lvl_q <= RST_VAL[gi];
                end else if (clk_en && (s2_q == s3_q)) begin
                    lvl_q <= s3_q;
                end
            end
            assign level_q[gi] = lvl_q;
        end
    endgenerate
endmodule : dar_sync
`default_nettype wire

/* File: include/dar_pkg.sv */
// Constants shared by the serial converter readout block.
`default_nettype none
package dar_pkg;
    // Result word and FIFO shape.
    localparam int WORD_W = 12;
    localparam int FIFO_DEPTH = 8;
    // Serial clock fall counter width.
    localparam int CNT_W = 5;
    // Serial clock falls counted from the select fall.
    localparam logic [CNT_W-1:0] FALL_NULL = 5'h02;
    localparam logic [CNT_W-1:0] FALL_MSB = 5'h03;
    localparam logic [CNT_W-1:0] FALL_LSB = 5'h0E;
    localparam logic [CNT_W-1:0] FALL_REPEAT = 5'h0F;
    localparam logic [CNT_W-1:0] FALL_LAST = 5'h19;
    localparam logic [CNT_W-1:0] FALL_OFF = 5'h1A;
    // Reset levels of the synchronised pins and of the sample word.
    localparam logic CS_N_RST = 1'b1;
    localparam logic SCLK_RST = 1'b0;
    localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
    // Frame states.
    typedef enum logic [2:0] {
        DAR_IDLE,
        DAR_SAMPLE,
        DAR_SHIFT,
        DAR_REPEAT,
        DAR_DONE
    } dar_state_e;
endpackage : dar_pkg
`default_nettype wire

/* File: testbench/dar_core_tb.sv */
// Self-checking bench for the converter serial readout block.
`default_nettype none
module dar_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dar_pkg::*;
    // ****************************************
    // Signals and instances.
    // ****************************************
    logic core_clk;
    logic srst;
    logic clk_en;
    logic [WORD_W-1:0] sample_data;
    logic sample_valid;
    wire logic cs_n_pin;
    wire logic sclk_pin;
    wire logic dout;
    wire logic dout_oe;
    wire logic sample_ready;
    wire logic sampling;
    wire logic analog_on;
    wire logic shift_on;
    wire logic sample_missing;
    wire logic [WORD_W-1:0] result;
    wire logic result_valid;
    integer seed;
    int miscompares;
    int total_checks;
    int valid_cnt;
    logic [WORD_W-1:0] exp_q[$];
    logic [WORD_W-1:0] last_w;
    logic [WORD_W-1:0] corner[4];
    dar_core dar_core_inst (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
        .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .dout(dout), .dout_oe(dout_oe),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sampling(sampling), .analog_on(analog_on),
        .shift_on(shift_on), .sample_missing(sample_missing), .result(result),
        .result_valid(result_valid));
    dar_host_model dar_host_model_inst (.core_clk(core_clk), .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin), .dout(dout), .dout_oe(dout_oe));
    // ****************************************
    // Expectations and helpers.
    // ****************************************
    function automatic logic exp_oe(input int f);
        return (f >= 2) && (f <= 25);
    endfunction : exp_oe
    function automatic logic exp_bit(input logic [WORD_W-1:0] w, input int f);
        if (f >= 3 && f <= 14) begin
            return w[14-f];
        end
        if (f >= 15 && f <= 25) begin
            return w[f-14];
        end
        return 1'b0;
    endfunction : exp_bit
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic push(input logic [WORD_W-1:0] w);
        int i;
        @(posedge core_clk);
        exp_q.push_back(w);
        sample_data <= w;
        sample_valid <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge core_clk);
            if (sample_ready === 1'b1) begin
                break;
            end
        end
        sample_valid <= 1'b0;
        if (i == 64) begin
            miscompares++;
            summarize();
        end
    endtask : push
    task automatic run(input int n, input bit early, input bit keep);
        logic [WORD_W-1:0] w;
        logic miss;
        int f;
        int v0;
        miss = (exp_q.size() == 0);
        v0 = valid_cnt;
        w = miss ? 12'h000 : exp_q[0];
        if (n + early >= 2 && !miss) begin
            void'(exp_q.pop_front());
        end
        dar_host_model_inst.frame(n, early, keep);
        for (int j = 1; j <= n; j++) begin
            f = j + early;
            chk(dar_host_model_inst.oe_q[j], exp_oe(f));
            if (exp_oe(f)) begin
                chk(dar_host_model_inst.bit_q[j], exp_bit(w, f));
            end
        end
        if (n + early >= 2) begin
            chk(sample_missing, miss);
        end
        chk(16'(valid_cnt - v0), 16'(n + early >= 14));
        if (n + early >= 14) begin
            last_w = w;
            chk(result, w);
        end
        if (!keep) begin
            chk({dout_oe, shift_on}, 2'b00);
        end
    endtask : run
    // ****************************************
    // Clock, reset and scenarios.
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Counts result pulses so that each frame reaching fall fourteen can be held to exactly one, and a shorter one to none.
    always @(posedge core_clk) begin
        if (srst) begin
            valid_cnt <= 0;
        end else if (result_valid === 1'b1) begin
            valid_cnt <= valid_cnt + 1;
        end
    end
    initial begin
        seed = 32'h74D1;
        srst = 1'b1;
        clk_en = 1'b1;
        sample_data = '0;
        sample_valid = 1'b0;
        last_w = '0;
        corner = '{12'h7FF, 12'h800, 12'h000, 12'hFFF};
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk({dout_oe, shift_on, sample_ready, result}, 16'h1000);
        for (int k = 0; k < 4; k++) begin
            push(corner[k]);
            run(16, 1'b0, 1'b0);
        end
        $display("test corners done");
        for (int k = 0; k < 6; k++) begin
            push(WORD_W'($random(seed)));
            run(($random(seed) & 1) ? 14 : 16, 1'b0, 1'b0);
        end
        $display("test random burst done");
        for (int k = 0; k < 8; k++) begin
            push(WORD_W'($random(seed)));
        end
        @(posedge core_clk);
        chk(sample_ready, 1'b0);
        run(30, 1'b0, 1'b1);
        chk({analog_on, shift_on, sample_ready}, 3'b001);
        push(WORD_W'($random(seed)));
        for (int k = 0; k < 4; k++) begin
            dar_host_model_inst.tick(1'b1);
        end
        chk({sample_ready, dout_oe}, 2'b00);
        dar_host_model_inst.release_cs();
        for (int k = 0; k < 8; k++) begin
            run(16, k == 0, 1'b0);
        end
        $display("test fill and repeat done");
        run(16, 1'b0, 1'b0);
        chk(sample_missing, 1'b1);
        run(1, 1'b0, 1'b1);
        chk({sampling, analog_on}, 2'b11);
        dar_host_model_inst.release_cs();
        chk({sampling, analog_on}, 2'b00);
        $display("test empty and abort done");
        push(WORD_W'($random(seed)));
        run(16, 1'b0, 1'b1);
        chk({analog_on, shift_on, sampling, dout_oe}, 4'b0101);
        // A low clock enable must hold the frame while the select pin rises.
        clk_en <= 1'b0;
        dar_host_model_inst.release_cs();
        chk({dout_oe, shift_on}, 2'b11);
        clk_en <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk({dout_oe, shift_on}, 2'b00);
        push(WORD_W'($random(seed)));
        run(9, 1'b0, 1'b0);
        chk(result, last_w);
        chk(analog_on, 1'b0);
        $display("test hold and short cycle done");
        summarize();
    end
endmodule : dar_core_tb
`default_nettype wire

/* File: testbench/dar_host_model.sv */
// Host serial controller model that frames the converter link.
`default_nettype none
module dar_host_model (
    // Clocking.
    input wire logic core_clk,
    // Serial link pins.
    output var logic cs_n_pin,
    output var logic sclk_pin,
    input wire logic dout,
    input wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 10;
    logic [31:0] bit_q;
    logic [31:0] oe_q;
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        bit_q = '0;
        oe_q = '0;
    end
    task automatic half_wait();
        repeat (HALF) @(posedge core_clk);
    endtask : half_wait
    task automatic tick(input bit rise);
        if (rise) begin
            sclk_pin <= 1'b1;
            half_wait();
        end
        sclk_pin <= 1'b0;
        half_wait();
    endtask : tick
    task automatic release_cs();
        sclk_pin <= 1'b1;
        half_wait();
        cs_n_pin <= 1'b1;
        half_wait();
        sclk_pin <= 1'b0;
        half_wait();
    endtask : release_cs
    task automatic frame(input int n, input bit early, input bit keep);
        bit_q = '0;
        oe_q = '0;
        if (early) begin
            sclk_pin <= 1'b1;
            half_wait();
        end
        cs_n_pin <= 1'b0;
        half_wait();
        for (int j = 1; j <= n; j++) begin
            tick(!early || j > 1);
            bit_q[j] = dout;
            oe_q[j] = dout_oe;
        end
        if (!keep) begin
            release_cs();
        end
    endtask : frame
endmodule : dar_host_model
`default_nettype wire
